// file: rtl/plld_pkg.sv
// Constants for the lock detector block.
package plld_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int ANALOG_WIN_NS = 10;
    localparam int ANALOG_WIN_RAW = ANALOG_WIN_NS / CLK_PERIOD_NS;
    localparam int ANALOG_WIN_CYC = (ANALOG_WIN_RAW < 1) ? 1 : ANALOG_WIN_RAW;

    localparam int WIN_W = 12;

    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_WINDOW     = 8'h04;
    localparam logic [7:0] OFS_RUNLEN     = 8'h08;
    localparam logic [7:0] OFS_PUMP       = 8'h0C;
    localparam logic [7:0] OFS_CSP        = 8'h10;
    localparam logic [7:0] OFS_STATUS     = 8'h14;
    localparam logic [7:0] OFS_INT_STATUS = 8'h18;
    localparam logic [7:0] OFS_INT_MASK   = 8'h1C;

    localparam int CTRL_LOCK_EN  = 0;
    localparam int CTRL_RING_SEL = 1;
    localparam int CTRL_ASYM_EN  = 2;
    localparam int CTRL_ASYM_DLY = 3;
    localparam int CTRL_CSP_EN   = 4;
    localparam int CTRL_PIN_ON   = 5;
    localparam int CTRL_W        = 6;

    localparam int WIN_RING_CFG_LSB = 0;
    localparam int WIN_DURATION_LSB = 8;
    localparam int RING_CFG_W       = 4;
    localparam int DURATION_W       = 8;

    localparam int PUMP_RISE_CUR_LSB  = 0;
    localparam int PUMP_FALL_CUR_LSB  = 4;
    localparam int PUMP_RISE_TRIM_LSB = 8;
    localparam int PUMP_FALL_TRIM_LSB = 12;
    localparam int PUMP_RISE_LEAK_LSB = 16;
    localparam int PUMP_FALL_LEAK_LSB = 20;

    localparam int CSP_MAGN_W = 4;

    localparam int INT_LOCK_GAINED = 0;
    localparam int INT_LOCK_LOST   = 1;
    localparam int INT_WIN_MISS    = 2;
    localparam int INT_W           = 3;

    localparam logic [CTRL_W-1:0] CTRL_RESET     = 6'h00;
    localparam logic [31:0]       WINDOW_RESET   = 32'h0000_0800;
    localparam logic [15:0]       RUNLEN_RESET   = 16'h03E8;
    localparam logic [31:0]       PUMP_RESET     = 32'h0000_0022;
    localparam logic [3:0]        CSP_RESET      = 4'h4;

    localparam logic [11:0] CUR_UA_SMALL = 12'd500;
    localparam logic [11:0] CUR_UA_LARGE = 12'd1000;
    localparam logic [11:0] TRIM_UA_LSB  = 12'd7;
    localparam logic [11:0] LEAK_UA_LSB  = 12'd55;
endpackage : plld_pkg

// file: rtl/plld_top.sv
// Lock detector, cycle slip control and pump setting decode with an APB register file.
//
// Overview of operation
// - Lock detection runs only while its enable bit is set.
// - Ring source clear: a fixed window of one 8 ns clock (10 ns rounded down) sits on each reference edge.
// - Ring source set: the window is a programmed number of ring periods.
// - Lock rises after the programmed count of consecutive in-window arrivals.
// - One arrival outside the window drops lock at once.
// - Once dropped, lock stays low until a full new run is seen.
// - A read-only status bit reads 1 while locked.
// - Pin enable set: the shared pin shows lock, or serial data during a read.
// - Asymmetric enable with delay select set puts the window after the reference.
// - Asymmetric enable with delay select clear puts the window before it.
// - Slip prevention holds detector gain at maximum until the frequencies match.
// - A magnitude setting adjusts how soon slip prevention lets go.
// - Each 3-bit current select switches two 500 uA sources and one 1000 uA source.
// - Each 4-bit trim adds 7 uA per step, up to 105 uA.
// - Each 3-bit leakage field adds 55 uA per step, up to 385 uA.
`timescale 1ns/10ps
module plld_top
    import plld_pkg::*;
#(
    parameter int RUN_W = 16
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ref_edge,
    input  wire logic        vco_edge,
    input  wire logic        serial_read_active,
    input  wire logic        serial_read_data,
    output logic             lock_or_readback_pin,
    output logic             lock_or_readback_pin_oe,
    output logic             locked,
    output logic             pfd_gain_max,
    output logic [11:0]      pump_rise_current,
    output logic [11:0]      pump_fall_current,
    output logic [11:0]      rise_leakage_setting,
    output logic [11:0]      fall_leakage_setting,
    output logic             irq
);
    initial begin
        if (RUN_W < 1 || RUN_W > 16) begin
            $error("RUN_W must lie between 1 and 16.");
        end
    end

    typedef enum logic [1:0] {
        PLLD_IDLE   = 2'b00,
        PLLD_ACCESS = 2'b01,
        PLLD_DONE   = 2'b11
    } plld_bus_e;

    typedef struct packed {
        plld_bus_e          bus;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic [CTRL_W-1:0]  ctrl;
        logic [31:0]        window;
        logic [RUN_W-1:0]   run_max;
        logic [31:0]        pump;
        logic [3:0]         csp_magn;
        logic [INT_W-1:0]   int_status;
        logic [INT_W-1:0]   int_mask;
        logic [RUN_W-1:0]   run_cnt;
        logic               locked;
        logic [WIN_W-1:0]   pre_len;
        logic [WIN_W-1:0]   post_len;
        logic [1:0]         ref_vco_seen;
        logic [3:0]         match_cnt;
        logic               gain_max;
        logic               pin;
        logic               pin_oe;
        logic [11:0]        rise_cur;
        logic [11:0]        fall_cur;
        logic [11:0]        rise_leak;
        logic [11:0]        fall_leak;
        logic               irq;
    } plld_state_s;

    plld_state_s r;
    plld_state_s next_r;
    logic        win_hit;
    logic        win_miss;

    // Two small sources sit on bits 0 and 2, the large one on bit 1.
    function automatic logic [11:0] pump_ua(input logic [2:0] sel, input logic [3:0] trim);
        logic [11:0] sum;
        sum = 12'd0;
        if (sel[0]) begin
            sum = sum + CUR_UA_SMALL;
        end
        if (sel[1]) begin
            sum = sum + CUR_UA_LARGE;
        end
        if (sel[2]) begin
            sum = sum + CUR_UA_SMALL;
        end
        sum = sum + 12'(trim * TRIM_UA_LSB);
        return sum;
    endfunction : pump_ua

    function automatic logic [11:0] leak_ua(input logic [2:0] sel);
        return 12'(sel * LEAK_UA_LSB);
    endfunction : leak_ua

    plld_win_judge u_judge (
        .clk      (clk),
        .rst      (rst),
        .enable   (r.ctrl[CTRL_LOCK_EN]),
        .ref_edge (ref_edge),
        .vco_edge (vco_edge),
        .pre_len  (r.pre_len),
        .post_len (r.post_len),
        .hit      (win_hit),
        .miss     (win_miss)
    );

    always_comb begin
        logic [WIN_W-1:0] win_len;
        logic [INT_W-1:0] events;
        logic [31:0]      rd;
        logic             mapped;
        logic             done;
        logic             was_locked;
        win_len = '0;
        events = '0;
        rd = 32'h0;
        mapped = 1'b1;
        done = 1'b0;
        was_locked = r.locked;
        next_r = r;

        // Bus slave: one wait state, so pready rises in the second access cycle.
        next_r.pready = 1'b0;
        case (r.bus)
            PLLD_IDLE: begin
                if (psel && !penable) begin
                    next_r.bus = PLLD_ACCESS;
                end
            end
            PLLD_ACCESS: begin
                if (paddr == OFS_CTRL) begin
                    rd = 32'(r.ctrl);
                end else if (paddr == OFS_WINDOW) begin
                    rd = r.window;
                end else if (paddr == OFS_RUNLEN) begin
                    rd = 32'(r.run_max);
                end else if (paddr == OFS_PUMP) begin
                    rd = r.pump;
                end else if (paddr == OFS_CSP) begin
                    rd = 32'(r.csp_magn);
                end else if (paddr == OFS_STATUS) begin
                    rd = {16'(r.run_cnt), 14'h0000, r.gain_max, r.locked};
                end else if (paddr == OFS_INT_STATUS) begin
                    rd = 32'(r.int_status);
                end else if (paddr == OFS_INT_MASK) begin
                    rd = 32'(r.int_mask);
                end else begin
                    mapped = 1'b0;
                end
                next_r.prdata = pwrite ? 32'h0 : rd;
                next_r.pslverr = !mapped;
                next_r.pready = 1'b1;
                next_r.bus = PLLD_DONE;
            end
            PLLD_DONE: begin
                done = 1'b1;
                next_r.pslverr = 1'b0;
                next_r.bus = (psel && !penable) ? PLLD_ACCESS : PLLD_IDLE;
            end
            default: begin
                next_r.bus = PLLD_IDLE;
            end
        endcase

        if (done && pwrite) begin
            if (paddr == OFS_CTRL) begin
                next_r.ctrl = pwdata[CTRL_W-1:0];
            end else if (paddr == OFS_WINDOW) begin
                next_r.window = pwdata;
            end else if (paddr == OFS_RUNLEN) begin
                next_r.run_max = pwdata[RUN_W-1:0];
            end else if (paddr == OFS_PUMP) begin
                next_r.pump = pwdata;
            end else if (paddr == OFS_CSP) begin
                next_r.csp_magn = pwdata[CSP_MAGN_W-1:0];
            end else if (paddr == OFS_INT_MASK) begin
                next_r.int_mask = pwdata[INT_W-1:0];
            end
        end

        // The ring window is duration times ring period, in clocks.
        if (r.ctrl[CTRL_RING_SEL]) begin
            win_len = WIN_W'(r.window[WIN_DURATION_LSB +: DURATION_W]
                * (r.window[WIN_RING_CFG_LSB +: RING_CFG_W] + 5'd1));
        end else begin
            win_len = WIN_W'(ANALOG_WIN_CYC);
        end
        if (r.ctrl[CTRL_ASYM_EN] && r.ctrl[CTRL_ASYM_DLY]) begin
            next_r.pre_len = '0;
            next_r.post_len = win_len;
        end else if (r.ctrl[CTRL_ASYM_EN]) begin
            next_r.pre_len = win_len;
            next_r.post_len = '0;
        end else begin
            next_r.pre_len = win_len >> 1;
            next_r.post_len = win_len - (win_len >> 1);
        end

        // A miss wins over a hit in the same cycle.
        if (!r.ctrl[CTRL_LOCK_EN]) begin
            next_r.run_cnt = '0;
            next_r.locked = 1'b0;
        end else if (win_miss) begin
            next_r.run_cnt = '0;
            next_r.locked = 1'b0;
            events[INT_WIN_MISS] = 1'b1;
        end else if (win_hit) begin
            if (r.run_cnt < r.run_max) begin
                next_r.run_cnt = r.run_cnt + 1'b1;
            end
            if ({1'b0, r.run_cnt} + 1'b1 >= {1'b0, r.run_max}) begin
                next_r.locked = 1'b1;
            end
        end
        events[INT_LOCK_GAINED] = next_r.locked && !was_locked;
        events[INT_LOCK_LOST] = !next_r.locked && was_locked;

        // One arrival per reference period counts as balanced.
        if (ref_edge) begin
            if (r.ref_vco_seen == 2'd1 || (r.ref_vco_seen == 2'd0 && vco_edge)) begin
                if (r.match_cnt != 4'hF) begin
                    next_r.match_cnt = r.match_cnt + 1'b1;
                end
            end else begin
                next_r.match_cnt = 4'h0;
            end
            next_r.ref_vco_seen = 2'd0;
        end else if (vco_edge && r.ref_vco_seen != 2'd2) begin
            next_r.ref_vco_seen = r.ref_vco_seen + 1'b1;
        end
        // Larger magnitudes need a longer balanced run before release.
        next_r.gain_max = r.ctrl[CTRL_CSP_EN] && (r.match_cnt < r.csp_magn);

        // Readback data wins while a serial read runs.
        if (serial_read_active) begin
            next_r.pin = serial_read_data;
            next_r.pin_oe = 1'b1;
        end else begin
            next_r.pin = r.locked;
            next_r.pin_oe = r.ctrl[CTRL_PIN_ON];
        end

        next_r.rise_cur = pump_ua(r.pump[PUMP_RISE_CUR_LSB +: 3], r.pump[PUMP_RISE_TRIM_LSB +: 4]);
        next_r.fall_cur = pump_ua(r.pump[PUMP_FALL_CUR_LSB +: 3], r.pump[PUMP_FALL_TRIM_LSB +: 4]);
        next_r.rise_leak = leak_ua(r.pump[PUMP_RISE_LEAK_LSB +: 3]);
        next_r.fall_leak = leak_ua(r.pump[PUMP_FALL_LEAK_LSB +: 3]);

        // An event in the clearing cycle survives the read.
        if (done && !pwrite && paddr == OFS_INT_STATUS) begin
            next_r.int_status = events;
        end else begin
            next_r.int_status = r.int_status | events;
        end
        next_r.irq = |(r.int_status & r.int_mask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{
                bus:      PLLD_IDLE,
                ctrl:     CTRL_RESET,
                window:   WINDOW_RESET,
                run_max:  RUN_W'(RUNLEN_RESET),
                pump:     PUMP_RESET,
                csp_magn: CSP_RESET,
                default:  '0
            };
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign lock_or_readback_pin = r.pin;
    assign lock_or_readback_pin_oe = r.pin_oe;
    assign locked = r.locked;
    assign pfd_gain_max = r.gain_max;
    assign pump_rise_current = r.rise_cur;
    assign pump_fall_current = r.fall_cur;
    assign rise_leakage_setting = r.rise_leak;
    assign fall_leakage_setting = r.fall_leak;
    assign irq = r.irq;
endmodule : plld_top

// file: rtl/plld_win_judge.sv
// Lock window judge: rates each divided VCO arrival as a hit or a miss.
`timescale 1ns/10ps
module plld_win_judge
    import plld_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             enable,
    input  wire logic             ref_edge,
    input  wire logic             vco_edge,
    input  wire logic [WIN_W-1:0] pre_len,
    input  wire logic [WIN_W-1:0] post_len,
    output logic                  hit,
    output logic                  miss
);
    typedef struct packed {
        logic [WIN_W-1:0] since_ref;
        logic [WIN_W-1:0] since_vco;
        logic             ref_open;
        logic             vco_pend;
        logic             hit;
        logic             miss;
    } plld_judge_s;

    plld_judge_s r;
    plld_judge_s next_r;

    always_comb begin
        next_r = r;
        next_r.hit = 1'b0;
        next_r.miss = 1'b0;
        if (r.since_ref != '1) begin
            next_r.since_ref = r.since_ref + 1'b1;
        end
        if (r.since_vco != '1) begin
            next_r.since_vco = r.since_vco + 1'b1;
        end
        if (!enable) begin
            next_r.ref_open = 1'b0;
            next_r.vco_pend = 1'b0;
        end else begin
            // An early arrival waits for the reference edge or the end of its pre-window.
            if (r.vco_pend && !ref_edge && (r.since_vco >= pre_len)) begin
                next_r.miss = 1'b1;
                next_r.vco_pend = 1'b0;
            end
            if (ref_edge) begin
                next_r.since_ref = '0;
                next_r.ref_open = 1'b1;
                if (r.vco_pend) begin
                    next_r.hit = 1'b1;
                    next_r.vco_pend = 1'b0;
                    next_r.ref_open = 1'b0;
                end
            end
            if (vco_edge) begin
                if (ref_edge && !r.vco_pend) begin
                    next_r.hit = 1'b1;
                    next_r.ref_open = 1'b0;
                end else if (!ref_edge && r.ref_open
                        && ({1'b0, r.since_ref} + 1'b1 < {1'b0, post_len})) begin
                    next_r.hit = 1'b1;
                    next_r.ref_open = 1'b0;
                end else if (pre_len != '0) begin
                    if (r.vco_pend && !ref_edge) begin
                        next_r.miss = 1'b1;
                    end
                    next_r.vco_pend = 1'b1;
                    next_r.since_vco = '0;
                end else begin
                    next_r.miss = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{since_ref: '1, since_vco: '1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign hit = r.hit;
    assign miss = r.miss;
endmodule : plld_win_judge

// file: verif/plld_edge_src.sv
// Model of the divided reference and VCO edges at the phase detector.
`timescale 1ns/10ps
module plld_edge_src #(
    parameter int PERIOD = 20
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [4:0] ofs,
    input  wire logic       vco_on,
    output logic            ref_edge,
    output logic            vco_edge
);
    logic [4:0] cnt;
    logic [4:0] ofs_q;
    // The offset is taken once a period, so changes move whole periods.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt      <= '0;
            ofs_q    <= '0;
            ref_edge <= 1'b0;
            vco_edge <= 1'b0;
        end else begin
            cnt      <= (cnt == 5'(PERIOD - 1)) ? '0 : cnt + 5'h01;
            ofs_q    <= (cnt == 5'(PERIOD - 1)) ? ofs : ofs_q;
            ref_edge <= (cnt == '0);
            vco_edge <= vco_on && (cnt == ofs_q);
        end
    end
endmodule : plld_edge_src

// file: verif/plld_top_chk.sv
// Port checks for the lock detector block.
`timescale 1ns/10ps
module plld_top_chk
    import plld_pkg::*;
#(
    parameter int RUN_W = 16
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        ref_edge,
    input wire logic        vco_edge,
    input wire logic        serial_read_active,
    input wire logic        serial_read_data,
    input wire logic        lock_or_readback_pin,
    input wire logic        lock_or_readback_pin_oe,
    input wire logic        locked,
    input wire logic        pfd_gain_max,
    input wire logic [11:0] pump_rise_current,
    input wire logic [11:0] rise_leakage_setting
);
    logic [31:0] ctrl_q;
    logic [31:0] pump_q;
    logic [3:0]  csp_q;
    logic [11:0] exp_rise;
    logic        wr_done;
    assign wr_done  = psel && penable && pready && pwrite;
    assign exp_rise = (pump_q[0] ? CUR_UA_SMALL : 12'h000) + (pump_q[1] ? CUR_UA_LARGE : 12'h000)
                    + (pump_q[2] ? CUR_UA_SMALL : 12'h000) + TRIM_UA_LSB * {8'h00, pump_q[11:8]};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= '0;
            pump_q <= PUMP_RESET;
            csp_q  <= CSP_RESET;
        end else if (wr_done) begin
            ctrl_q <= (paddr == OFS_CTRL) ? pwdata : ctrl_q;
            pump_q <= (paddr == OFS_PUMP) ? pwdata : pump_q;
            csp_q  <= (paddr == OFS_CSP) ? pwdata[3:0] : csp_q;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_lock_gate;
        (!ctrl_q[CTRL_LOCK_EN]) [*3] |-> !locked;
    endproperty
    a_lock_gate: assert property (p_lock_gate) else $error("lock while off");
    property p_lock_rise;
        $rose(locked) |-> $past(vco_edge, 2) || $past(ref_edge, 2);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock without arrival");
    property p_miss_drop;
        (ctrl_q[2:0] == 3'h1) [*3] ##0 (vco_edge && !ref_edge) |-> ##2 !locked;
    endproperty
    a_miss_drop: assert property (p_miss_drop) else $error("lock after miss");
    property p_status;
        psel && penable && pready && !pwrite && paddr == OFS_STATUS && $stable(locked)
            |-> prdata[0] == locked;
    endproperty
    a_status: assert property (p_status) else $error("status bit wrong");
    property p_pin_read;
        serial_read_active && $past(serial_read_active)
            |-> lock_or_readback_pin_oe && lock_or_readback_pin == $past(serial_read_data);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin not read data");
    property p_pin_lock;
        (ctrl_q[CTRL_PIN_ON] && !serial_read_active) [*3]
            |-> lock_or_readback_pin_oe && lock_or_readback_pin == $past(locked);
    endproperty
    a_pin_lock: assert property (p_pin_lock) else $error("pin not showing lock");
    property p_gain_off;
        (!ctrl_q[CTRL_CSP_EN]) [*3] |-> !pfd_gain_max;
    endproperty
    a_gain_off: assert property (p_gain_off) else $error("gain with slip off");
    property p_magn_zero;
        (csp_q == 4'h0) [*3] |-> !pfd_gain_max;
    endproperty
    a_magn_zero: assert property (p_magn_zero) else $error("gain at zero magnitude");
    property p_rise_cur;
        (pump_q == $past(pump_q)) [*2] |-> pump_rise_current == exp_rise;
    endproperty
    a_rise_cur: assert property (p_rise_cur) else $error("rise current wrong");
    property p_rise_leak;
        (pump_q == $past(pump_q)) [*2] |-> rise_leakage_setting == LEAK_UA_LSB * {9'h000, pump_q[18:16]};
    endproperty
    a_rise_leak: assert property (p_rise_leak) else $error("rise leakage wrong");
endmodule : plld_top_chk
bind plld_top plld_top_chk #(.RUN_W(RUN_W)) u_chk (.*);

// file: verif/plld_top_tb.sv
// Testbench for the lock detector block.
`timescale 1ns/10ps
module plld_top_tb
    import plld_pkg::*;
;
    localparam int P = 20;
    localparam int NROW = 11;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata, v;
    logic pready, pslverr, rerr, ref_edge, vco_edge, srd_act = 1'b0, srd_dat = 1'b0;
    logic pin, pin_oe, locked, pfd_gain_max, irq, vco_on = 1'b1;
    logic [4:0] ofs = '0;
    logic [11:0] rise_cur, fall_cur, rise_leak, fall_leak;
    int err_total = 0, n_checks = 0;
    // Rows: ctrl, window, offset, expected lock.
    logic [7:0] t_ctrl [NROW] = '{8'h01, 8'h00, 8'h01, 8'h03, 8'h03, 8'h03, 8'h03, 8'h0F, 8'h0F,
                                  8'h07, 8'h07};
    logic [15:0] t_win [NROW] = '{16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0301,
                                  16'h0301, 16'h0800, 16'h0800, 16'h0800, 16'h0800};
    logic [4:0] t_ofs [NROW] = '{5'h00, 5'h00, 5'h01, 5'h03, 5'h05, 5'h02, 5'h03, 5'h07, 5'h12,
                                 5'h11, 5'h01};
    logic t_exp [NROW] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] r_adr [6] = '{OFS_CTRL, OFS_WINDOW, OFS_RUNLEN, OFS_PUMP, OFS_CSP, OFS_INT_MASK};
    logic [31:0] r_val [6] = '{32'h0, WINDOW_RESET, 32'(RUNLEN_RESET), PUMP_RESET,
                               32'(CSP_RESET), 32'h0};
    always #4 clk = ~clk;
    plld_edge_src #(.PERIOD(P)) u_src (.clk(clk), .rst(rst), .ofs(ofs), .vco_on(vco_on),
        .ref_edge(ref_edge), .vco_edge(vco_edge));
    plld_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_edge(ref_edge), .vco_edge(vco_edge), .serial_read_active(srd_act),
        .serial_read_data(srd_dat), .lock_or_readback_pin(pin), .lock_or_readback_pin_oe(pin_oe),
        .locked(locked), .pfd_gain_max(pfd_gain_max), .pump_rise_current(rise_cur),
        .pump_fall_current(fall_cur), .rise_leakage_setting(rise_leak),
        .fall_leakage_setting(fall_leak), .irq(irq));
    function automatic logic [11:0] cur_ua(input logic [2:0] s, input logic [3:0] t);
        return (s[0] ? CUR_UA_SMALL : 12'h000) + (s[1] ? CUR_UA_LARGE : 12'h000)
             + (s[2] ? CUR_UA_SMALL : 12'h000) + TRIM_UA_LSB * {8'h00, t};
    endfunction : cur_ua
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One transfer; the slave sets the pace.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic results();
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    initial begin
        #400000;
        err_total++;
        results();
    end
    initial begin
        int n;
        tick(8);
        rst <= 1'b0;
        tick(2);
        chk("rise", 32'(CUR_UA_LARGE), 32'(rise_cur));
        chk("fall", 32'(CUR_UA_LARGE), 32'(fall_cur));
        chk("irq", 32'h0, 32'(irq));
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, r_adr[i], '0);
            chk("reset_reg", r_val[i], rdata);
        end
        apb(1'b0, 8'h20, '0);
        chk("slverr", 32'h1, 32'(rerr));
        chk("unmapped", 32'h0, rdata);
        apb(1'b1, OFS_RUNLEN, 32'h3);
        for (int i = 0; i < NROW; i++) begin
            apb(1'b1, OFS_WINDOW, 32'(t_win[i]));
            apb(1'b1, OFS_CTRL, 32'(t_ctrl[i]));
            ofs <= t_ofs[i];
            tick(8 * P);
            chk("locked", 32'(t_exp[i]), 32'(locked));
            apb(1'b0, OFS_STATUS, '0);
            chk("status", 32'(t_exp[i]), 32'(rdata[0]));
        end
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        ofs <= '0;
        tick(8 * P);
        apb(1'b0, OFS_INT_STATUS, '0);
        apb(1'b1, OFS_INT_MASK, 32'h0000_0007);
        ofs <= 5'h05;
        tick(P);
        ofs <= '0;
        n = 0;
        while (locked !== 1'b0 && n < 3 * P) begin
            tick(1);
            n++;
        end
        v = '0;
        n = 0;
        while (locked !== 1'b1 && n < 6 * P) begin
            tick(1);
            n++;
            v = (vco_edge === 1'b1) ? v + 32'h1 : v;
        end
        chk("relock_hits", 32'h3, v);
        tick(4);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, OFS_INT_MASK, '0);
        tick(3);
        chk("irq_masked", 32'h0, 32'(irq));
        apb(1'b1, OFS_INT_MASK, 32'h0000_0007);
        tick(3);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b0, OFS_INT_STATUS, '0);
        chk("int_status", 32'h7, rdata);
        apb(1'b0, OFS_INT_STATUS, '0);
        chk("int_cleared", 32'h0, rdata);
        tick(3);
        chk("irq_cleared", 32'h0, 32'(irq));
        apb(1'b1, OFS_CTRL, 32'h21);
        tick(3);
        chk("pin_lock", 32'h3, 32'({pin_oe, pin}));
        srd_act <= 1'b1;
        tick(3);
        chk("pin_read0", 32'h2, 32'({pin_oe, pin}));
        srd_dat <= 1'b1;
        tick(2);
        chk("pin_read1", 32'h3, 32'({pin_oe, pin}));
        srd_dat <= 1'b0;
        tick(2);
        srd_act <= 1'b0;
        tick(3);
        chk("pin_back", 32'h3, 32'({pin_oe, pin}));
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        tick(3);
        chk("pin_off", 32'h0, 32'(pin_oe));
        apb(1'b1, OFS_CSP, 32'h8);
        apb(1'b1, OFS_CTRL, 32'h11);
        vco_on <= 1'b0;
        tick(3 * P);
        chk("gain_slip", 32'h1, 32'(pfd_gain_max));
        vco_on <= 1'b1;
        tick(4 * P);
        chk("gain_short", 32'h1, 32'(pfd_gain_max));
        tick(6 * P);
        chk("gain_match", 32'h0, 32'(pfd_gain_max));
        apb(1'b1, OFS_CSP, '0);
        vco_on <= 1'b0;
        tick(3 * P);
        chk("gain_zero", 32'h0, 32'(pfd_gain_max));
        vco_on <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = (32'(7 - i) << 20) | (32'(i) << 16) | (32'(15 - i) << 12) | (32'(2 * i) << 8)
              | (32'(7 - i) << 4) | 32'(i);
            apb(1'b1, OFS_PUMP, v);
            tick(2);
            chk("rise_cur", 32'(cur_ua(3'(i), 4'(2 * i))), 32'(rise_cur));
            chk("fall_cur", 32'(cur_ua(3'(7 - i), 4'(15 - i))), 32'(fall_cur));
            chk("rise_leak", 32'(LEAK_UA_LSB * 12'(i)), 32'(rise_leak));
            chk("fall_leak", 32'(LEAK_UA_LSB * 12'(7 - i)), 32'(fall_leak));
        end
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(2);
        chk("rise_rst", 32'(CUR_UA_LARGE), 32'(rise_cur));
        apb(1'b0, OFS_CTRL, '0);
        chk("ctrl_rst", 32'h0, rdata);
        results();
    end
endmodule : plld_top_tb
